// File: mio_pkg.sv
/*
 * Shared constants for the multi-user I/O port decoder: relative port
 * numbers, user-select field layout, switch vector layout, reset values.
 * Assumes an eight-bit I/O address and data bus on a single bus clock.
 */
`default_nettype none

package mio_pkg;

   // Relative ports inside the eight-port block
   localparam logic [2:0] PORT_DATA = 3'h0;
   localparam logic [2:0] PORT_STAT = 3'h1;
   localparam logic [2:0] PORT_MODE = 3'h2;
   localparam logic [2:0] PORT_CMD = 3'h3;
   localparam logic [2:0] PORT_TXIRQ = 3'h4;
   localparam logic [2:0] PORT_RXIRQ = 3'h5;
   localparam logic [2:0] PORT_UNUSED = 3'h6;
   localparam logic [2:0] PORT_USEL = 3'h7;
   localparam logic [2:0] PORT_FIRST_IRQ = 3'h4;

   // User-select register layout
   localparam int USEL_W = 5;
   localparam int USEL_RELATIVE_USER_BIT0 = 0;
   localparam int USEL_RELATIVE_USER_BIT1 = 1;
   localparam int USEL_HALF_SELECT_BIT = 2;
   localparam int USEL_GRP_LSB = 3;
   localparam logic [4:0] USEL_RESET = 5'h00;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // Synchronised switch vector layout
   localparam int SW_BASE_LSB = 0;
   localparam int SW_BLK_OFF = 5;
   localparam int SW_GRP_LSB = 6;
   localparam int SW_HALF = 8;
   localparam int SW_NIB = 9;
   localparam int SW_SWAP = 10;
   localparam int SW_WAIT_LSB = 11;
   localparam int SW_OPT_LSB = 14;
   localparam int SW_W = 22;

   // Physical channel numbers and the pair swapped by the jumper
   localparam logic [1:0] PAR_CHAN = 2'h0;
   localparam logic [1:0] SWAP_A = 2'h0;
   localparam logic [1:0] SWAP_B = 2'h2;
   localparam logic [1:0] SWAP_XOR = 2'h2;

   // Wait-state counts for no jumper and for the three jumper positions
   localparam logic [1:0] WAIT_NONE = 2'h0;
   localparam logic [1:0] WAIT_ONE = 2'h1;
   localparam logic [1:0] WAIT_TWO = 2'h2;
   localparam logic [1:0] WAIT_THREE = 2'h3;

   // Data-bus drive patterns, low enable drives the bit
   localparam logic [7:0] OE_NONE = 8'hFF;
   localparam logic [7:0] OE_ALL = 8'h00;
   localparam logic [7:0] OE_LOW_NIB = 8'hF0;
   localparam logic [7:0] OE_HIGH_NIB = 8'h0F;

   localparam int IRQ_LINES = 8;
   localparam int IRQ_SRCS = 8;

endpackage

`default_nettype wire

// File: mio_wait_gen.sv
/*
 * Wait-state generator: stretches a channel access by 0 to 3 bus cycles.
 * Assumes start is a one-cycle pulse from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module mio_wait_gen
   import mio_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [1:0] count,
   output logic busy,
   output logic done
);

   typedef struct packed {
      logic [1:0] rem;
      logic last;
   } mio_wait_st_t;

   mio_wait_st_t q;
   mio_wait_st_t d;

   always_comb begin
      d = q;
      d.last = 1'b0;
      if (start) begin
         d.rem = 2'(count - WAIT_ONE);
         d.last = (count == WAIT_ONE);
         if (count == WAIT_NONE) begin
            d.rem = WAIT_NONE;
         end
      end else if (q.rem != WAIT_NONE) begin
         d.rem = 2'(q.rem - WAIT_ONE);
         d.last = (q.rem == WAIT_ONE);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy = (start && count != WAIT_NONE) || q.rem != WAIT_NONE;
   assign done = (start && count == WAIT_NONE) || q.last;

   chk_wait_two_cycles:
      assert property (@(posedge clk) disable iff (!rst_n)
         (start && count == WAIT_TWO) |-> busy [*2] ##1 (!busy && done))
      else $error("two wait states not held for exactly two cycles");

endmodule // mio_wait_gen

`default_nettype wire

// File: mio_irq_route.sv
/*
 * Interrupt routing: masked sources onto the eight open-collector
 * vectored lines through a jumper matrix. Route jumpers are static pins.
 */
`timescale 1ns/100ps
`default_nettype none

module mio_irq_route
   import mio_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [IRQ_SRCS-1:0] src,
   input wire logic [IRQ_LINES*IRQ_SRCS-1:0] route,
   output logic [IRQ_LINES-1:0] line_o,
   output logic [IRQ_LINES-1:0] line_oe_n
);

   typedef struct packed {
      logic [IRQ_LINES*IRQ_SRCS-1:0] r1;
      logic [IRQ_LINES*IRQ_SRCS-1:0] r2;
      logic [IRQ_LINES-1:0] oe_n;
   } mio_irq_st_t;

   mio_irq_st_t q;
   mio_irq_st_t d;
   logic [IRQ_LINES-1:0] pull;

   // Any source jumpered to a line pulls it low; several boards may share it
   genvar j;
   generate
      for (j = 0; j < IRQ_LINES; j++) begin : g_line
         assign pull[j] = |(src & q.r2[j*IRQ_SRCS +: IRQ_SRCS]);
      end
   endgenerate

   always_comb begin
      d = q;
      d.r1 = route;
      d.r2 = q.r1;
      d.oe_n = ~pull;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.oe_n <= '1;
      end else begin
         q <= d;
      end
   end

   assign line_o = '0;
   assign line_oe_n = q.oe_n;

   chk_irq_masked_quiet:
      assert property (@(posedge clk) disable iff (!rst_n)
         (src == '0) |=> (&line_oe_n))
      else $error("interrupt line driven with every source masked");

endmodule // mio_irq_route

`default_nettype wire

// File: mio_port_decoder.sv
/*
 * Top of the multi-user I/O port decoder: bus decode of the eight-port
 * block, user select, interrupt status and masks, channel steering,
 * wait states and interrupt routing.
 * Assumes bus strobes are synchronous to CLOCK; switches and jumpers are
 * static pins and are synchronised; channel chips run on CLOCK.
 */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Block of eight ports at a switch-chosen multiple of eight.
// - Address bits 7..3 compared to switches; closed means zero, open means one.
// - Disable switch closed: ignore every access and never drive data.
// - Port 7 is write-only user select; port 6 unused; neither drives reads.
// - Five-bit user select picks one of 32 users over eight boards.
// - Selected user's channel registers appear at ports 0 to 3.
// - Interrupt registers reachable whenever any user of our group of eight is selected.
// - Port 4 reads transmit pending status, writes transmit mask.
// - Port 5 reads receive pending status, writes receive mask.
// - Port 0 is channel data; parallel user reads the option switches.
// - Port 1 reads status, writes sync character or printer control.
// - Port 2 is USART mode or parallel data.
// - Port 3 is USART command or parallel status.
// - Eight interrupt sources, each jumperable to any vectored line.
// - Interrupt outputs are open collector and shareable.
// - A source whose mask bit is clear never requests.
// - Status registers show pending conditions regardless of mask.
// - Jumpers give one, two or three wait states, or none.
// - Swap jumper exchanges printer port and middle serial channel.
// - User select: bits 1..0 user, bit 2 half, bits 4..3 group.
// - Only channel register accesses get wait states.
// - Switch steers interrupt status and masks to high or low nibble.
module mio_port_decoder
   import mio_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] DATA_OUT,
   input wire logic SINP,
   input wire logic SOUT,
   input wire logic PDBIN,
   input wire logic PWR_N,
   output logic [7:0] DATA_IN,
   output logic [7:0] DATA_IN_OE_N,
   output logic RDY_O,
   output logic RDY_OE_N,
   input wire logic [4:0] BASE_SW_CLOSED,
   input wire logic PORT_BLOCK_DISABLE,
   input wire logic GROUP_SELECT_LOW_SWITCH,
   input wire logic GROUP_SELECT_HIGH_SWITCH,
   input wire logic HALF_SWITCH,
   input wire logic NIBBLE_STEER_SWITCH,
   input wire logic PRINTER_USER_SWAP_JUMPER,
   input wire logic [2:0] WAIT_JUMPER,
   input wire logic [7:0] OPTION_SW,
   input wire logic [63:0] IRQ_ROUTE,
   input wire logic [3:0] TX_PEND,
   input wire logic [3:0] RX_PEND,
   output logic [7:0] VI_O,
   output logic [7:0] VI_OE_N,
   output logic [3:0] CHAN_SEL,
   output logic [1:0] CHAN_REG,
   output logic CHAN_RD,
   output logic CHAN_WR,
   output logic [7:0] CHAN_WDATA,
   input wire logic [7:0] CHAN_RDATA
);

   typedef struct packed {
      logic [SW_W-1:0] sw1;
      logic [SW_W-1:0] sw2;
      logic strobe;
      logic start;
      logic wr;
      logic ch;
      logic [1:0] reg_a;
      logic [USEL_W-1:0] usel;
      logic [3:0] txm;
      logic [3:0] rxm;
      logic [7:0] wdata;
      logic [7:0] din;
      logic [7:0] oe_n;
   } mio_dec_st_t;

   mio_dec_st_t q;
   mio_dec_st_t d;

   logic [SW_W-1:0] sw;
   logic blk_off;
   logic strobe;
   logic start;
   logic blk_hit;
   logic [2:0] port;
   logic [1:0] my_grp;
   logic my_half;
   logic grp_hit;
   logic user_hit;
   logic [1:0] rel;
   logic [1:0] phys;
   logic nib_hi;
   logic [3:0] wr_nib;
   logic [3:0] rd_nib;
   logic [1:0] wait_n;
   logic wait_busy;
   logic wait_done;

   // Static settings, only the second sync stage is used
   assign sw = q.sw2;
   assign blk_off = sw[SW_BLK_OFF];
   assign nib_hi = sw[SW_NIB];

   assign strobe = (SINP && PDBIN) || (SOUT && !PWR_N);
   assign start = strobe && !q.strobe;
   assign port = ADDR[2:0];
   assign blk_hit = (ADDR[7:3] == ~sw[SW_BASE_LSB +: 5]) && !blk_off;

   assign my_grp = ~sw[SW_GRP_LSB +: 2];
   assign my_half = ~sw[SW_HALF];
   assign grp_hit = q.usel[USEL_GRP_LSB +: 2] == my_grp;
   assign user_hit = grp_hit && q.usel[USEL_HALF_SELECT_BIT] == my_half;
   assign rel = {q.usel[USEL_RELATIVE_USER_BIT1], q.usel[USEL_RELATIVE_USER_BIT0]};

   always_comb begin
      phys = rel;
      if (sw[SW_SWAP] && (rel == SWAP_A || rel == SWAP_B)) begin
         phys = rel ^ SWAP_XOR;
      end
   end

   // Mask nibble chosen by the steering switch, status nibble by the port
   assign wr_nib = nib_hi ? DATA_OUT[7:4] : DATA_OUT[3:0];
   assign rd_nib = (port == PORT_TXIRQ) ? TX_PEND : RX_PEND;

   always_comb begin
      if (sw[SW_WAIT_LSB + 2]) begin
         wait_n = WAIT_THREE;
      end else if (sw[SW_WAIT_LSB + 1]) begin
         wait_n = WAIT_TWO;
      end else if (sw[SW_WAIT_LSB]) begin
         wait_n = WAIT_ONE;
      end else begin
         wait_n = WAIT_NONE;
      end
   end

   always_comb begin
      d = q;
      d.sw1 = {OPTION_SW, WAIT_JUMPER, PRINTER_USER_SWAP_JUMPER, NIBBLE_STEER_SWITCH, HALF_SWITCH,
               GROUP_SELECT_HIGH_SWITCH, GROUP_SELECT_LOW_SWITCH, PORT_BLOCK_DISABLE, BASE_SW_CLOSED};
      d.sw2 = q.sw1;
      d.strobe = strobe;
      d.start = 1'b0;
      if (!strobe || blk_off) begin
         d.oe_n = OE_NONE;
      end
      if (start && blk_hit) begin
         d.start = 1'b1;
         d.wr = SOUT;
         d.reg_a = port[1:0];
         d.wdata = DATA_OUT;
         d.ch = user_hit && port < PORT_FIRST_IRQ;
         case (port)
            PORT_TXIRQ, PORT_RXIRQ: begin
               if (grp_hit && SOUT && port == PORT_TXIRQ) begin
                  d.txm = wr_nib;
               end else if (grp_hit && SOUT) begin
                  d.rxm = wr_nib;
               end else if (grp_hit) begin
                  d.din = nib_hi ? {rd_nib, 4'h0} : {4'h0, rd_nib};
                  d.oe_n = nib_hi ? OE_HIGH_NIB : OE_LOW_NIB;
               end
            end
            PORT_USEL: begin
               if (SOUT) begin
                  d.usel = DATA_OUT[USEL_W-1:0];
               end
            end
            PORT_UNUSED: begin
               d.ch = 1'b0;
            end
            default: begin
               if (user_hit && !SOUT) begin
                  d.oe_n = OE_ALL;
               end
            end
         endcase
      end
      if (CHAN_RD) begin
         if (phys == PAR_CHAN && q.reg_a == PORT_DATA[1:0]) begin
            d.din = sw[SW_OPT_LSB +: 8];
         end else begin
            d.din = CHAN_RDATA;
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         q <= '0;
         q.usel <= USEL_RESET;
         q.txm <= MASK_RESET;
         q.rxm <= MASK_RESET;
         q.oe_n <= OE_NONE;
      end else begin
         q <= d;
      end
   end

   mio_wait_gen u_wait (
      .clk(CLOCK),
      .rst_n(RESETN),
      .start(q.start && q.ch),
      .count(wait_n),
      .busy(wait_busy),
      .done(wait_done)
   );

   mio_irq_route u_irq (
      .clk(CLOCK),
      .rst_n(RESETN),
      .src({RX_PEND & q.rxm, TX_PEND & q.txm}),
      .route(IRQ_ROUTE),
      .line_o(VI_O),
      .line_oe_n(VI_OE_N)
   );

   assign RDY_O = 1'b0;
   assign RDY_OE_N = !wait_busy;
   assign CHAN_SEL = user_hit ? 4'(4'h1 << phys) : 4'h0;
   assign CHAN_REG = q.reg_a;
   assign CHAN_WDATA = q.wdata;
   assign CHAN_RD = wait_done && !q.wr;
   assign CHAN_WR = wait_done && q.wr;
   assign DATA_IN = q.din;
   assign DATA_IN_OE_N = q.oe_n;

   chk_disable_quiet:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         blk_off |=> (DATA_IN_OE_N == OE_NONE))
      else $error("data bus driven while block disabled");

   chk_user_latch:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (start && blk_hit && SOUT && port == PORT_USEL) |=> (q.usel == $past(DATA_OUT[4:0])))
      else $error("user select not loaded from write data");

   chk_usel_read_quiet:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (start && !SOUT && port >= PORT_UNUSED) |=> (DATA_IN_OE_N == OE_NONE))
      else $error("read of port six or seven drove the data bus");

   chk_tx_mask_load:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (start && blk_hit && grp_hit && SOUT && port == PORT_TXIRQ) |=> (q.txm == $past(wr_nib)))
      else $error("transmit mask not loaded");

   chk_rx_status_read:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (start && blk_hit && grp_hit && !SOUT && port == PORT_RXIRQ && !nib_hi)
         |=> (DATA_IN == {4'h0, $past(RX_PEND)} && DATA_IN_OE_N == OE_LOW_NIB))
      else $error("receive status not returned on low nibble");

   chk_no_wait_ctl:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (start && blk_hit && port >= PORT_FIRST_IRQ) |=> RDY_OE_N ##1 RDY_OE_N)
      else $error("control register access was stretched");

   chk_chan_strobe:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (q.start && q.ch && wait_n == WAIT_ONE && !q.wr) |-> (!RDY_OE_N && !CHAN_RD) ##1 (RDY_OE_N && CHAN_RD))
      else $error("channel read not issued after one wait state");

   chk_foreign_user:
      assert property (@(posedge CLOCK) disable iff (!RESETN)
         (!user_hit) |-> (CHAN_SEL == 4'h0))
      else $error("channel selected for a user of another board");

endmodule // mio_port_decoder

`default_nettype wire

// File: mio_host.sv
/*
 Bus master model for the port decoder: runs one I/O cycle at a time.
 Assumes it shares the bus clock with the decoder it talks to.
*/
`timescale 1ns/100ps
`default_nettype none

module mio_host (
   input wire logic clk,
   input wire logic [7:0] din,
   input wire logic [7:0] din_oe_n,
   input wire logic rdy_oe_n,
   output logic [7:0] addr,
   output logic [7:0] dout,
   output logic sinp,
   output logic sout,
   output logic pdbin,
   output logic pwr_n
);
   initial begin
      addr = 8'hFF;
      dout = 8'hA5;
      sinp = 1'b0;
      sout = 1'b0;
      pdbin = 1'b0;
      pwr_n = 1'b1;
   end

   // Strobe held until ready is released, data taken one edge later
   task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [7:0] oe, output int w, output bit to);
      int n;
      w = 0;
      @(posedge clk);
      #1;
      addr = a;
      dout = wr ? d : ~dout;
      sinp = !wr;
      pdbin = !wr;
      sout = wr;
      pwr_n = !wr;
      for (n = 0; n < 10; n++) begin
         @(posedge clk);
         #1;
         if (rdy_oe_n === 1'b1) break;
         w++;
      end
      to = (n == 10);
      @(posedge clk);
      #1;
      q = din;
      oe = din_oe_n;
      // Released lines stop showing the last value
      sinp = 1'b0;
      pdbin = 1'b0;
      sout = 1'b0;
      pwr_n = 1'b1;
      addr = ~a;
      dout = ~dout;
   endtask
endmodule // mio_host

`default_nettype wire

// File: multi_user_io_port_decoder_bench.sv
/*
 Self-checking bench for the port decoder: host model on the bus side,
 channel chips modelled by a read-data pattern.
 Assumes block base 10h, users 4..7 of group 0, as set below.
*/
`timescale 1ns/100ps
`default_nettype none

module multi_user_io_port_decoder_bench;
   import mio_pkg::*;
   logic CLOCK, RESETN, SINP, SOUT, PDBIN, PWR_N, RDY_O, RDY_OE_N, CHAN_RD, CHAN_WR;
   logic [7:0] ADDR, DATA_OUT, DATA_IN, DATA_IN_OE_N, OPTION_SW, VI_O, VI_OE_N, CHAN_WDATA, CHAN_RDATA;
   logic [4:0] BASE_SW_CLOSED;
   logic PORT_BLOCK_DISABLE, GROUP_SELECT_LOW_SWITCH, GROUP_SELECT_HIGH_SWITCH, HALF_SWITCH;
   logic NIBBLE_STEER_SWITCH, PRINTER_USER_SWAP_JUMPER;
   logic [2:0] WAIT_JUMPER;
   logic [63:0] IRQ_ROUTE;
   logic [3:0] TX_PEND, RX_PEND, CHAN_SEL;
   logic [1:0] CHAN_REG;
   int err_count = 0;
   int compares = 0;
   int rd_pulses = 0;
   int wr_pulses = 0;

   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end

   mio_port_decoder i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR), .DATA_OUT(DATA_OUT), .SINP(SINP),
      .SOUT(SOUT), .PDBIN(PDBIN), .PWR_N(PWR_N), .DATA_IN(DATA_IN), .DATA_IN_OE_N(DATA_IN_OE_N),
      .RDY_O(RDY_O), .RDY_OE_N(RDY_OE_N), .BASE_SW_CLOSED(BASE_SW_CLOSED),
      .PORT_BLOCK_DISABLE(PORT_BLOCK_DISABLE), .GROUP_SELECT_LOW_SWITCH(GROUP_SELECT_LOW_SWITCH),
      .GROUP_SELECT_HIGH_SWITCH(GROUP_SELECT_HIGH_SWITCH), .HALF_SWITCH(HALF_SWITCH),
      .NIBBLE_STEER_SWITCH(NIBBLE_STEER_SWITCH), .PRINTER_USER_SWAP_JUMPER(PRINTER_USER_SWAP_JUMPER),
      .WAIT_JUMPER(WAIT_JUMPER), .OPTION_SW(OPTION_SW), .IRQ_ROUTE(IRQ_ROUTE), .TX_PEND(TX_PEND),
      .RX_PEND(RX_PEND), .VI_O(VI_O), .VI_OE_N(VI_OE_N), .CHAN_SEL(CHAN_SEL), .CHAN_REG(CHAN_REG),
      .CHAN_RD(CHAN_RD), .CHAN_WR(CHAN_WR), .CHAN_WDATA(CHAN_WDATA), .CHAN_RDATA(CHAN_RDATA));

   mio_host i_host (.clk(CLOCK), .din(DATA_IN), .din_oe_n(DATA_IN_OE_N), .rdy_oe_n(RDY_OE_N),
      .addr(ADDR), .dout(DATA_OUT), .sinp(SINP), .sout(SOUT), .pdbin(PDBIN), .pwr_n(PWR_N));

   // Channel chips answer with their one-hot select and register number
   assign CHAN_RDATA = {CHAN_SEL, 2'h0, CHAN_REG};

   // Counts one-cycle channel strobes at the edge that ends them
   always @(posedge CLOCK) begin
      if (CHAN_RD === 1'b1) begin
         rd_pulses++;
      end
      if (CHAN_WR === 1'b1) begin
         wr_pulses++;
      end
   end

   task automatic end_sim();
      $display("Compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [7:0] oe, output int w);
      bit to;
      i_host.cyc(wr, a, d, q, oe, w, to);
      if (to) begin
         err_count++;
         $display("Error ready expected 1 seen 0");
         end_sim();
      end
   endtask

   // Lets static switch changes pass the synchronisers and routing
   task automatic settle();
      repeat (5) @(posedge CLOCK);
      #1;
   endtask

   task automatic t_usel();
      logic [7:0] q, oe;
      int w, s, r;
      for (s = 0; s < 2; s++) begin
         PRINTER_USER_SWAP_JUMPER = s[0];
         settle();
         for (r = 0; r < 4; r++) begin
            bus(1'b1, 8'h17, 8'(4 + r), q, oe, w);
            chk("chan_sel", {4'h0, CHAN_SEL}, 8'(1 << ((s == 1 && r % 2 == 0) ? r ^ 2 : r)));
         end
      end
      bus(1'b1, 8'h17, 8'h0D, q, oe, w);
      chk("chan_sel other group", {4'h0, CHAN_SEL}, 8'h00);
      GROUP_SELECT_LOW_SWITCH = 1'b0;
      HALF_SWITCH = 1'b1;
      settle();
      bus(1'b1, 8'h17, 8'h09, q, oe, w);
      chk("chan_sel group one low half", {4'h0, CHAN_SEL}, 8'h02);
      bus(1'b1, 8'h17, 8'h05, q, oe, w);
      chk("chan_sel old group", {4'h0, CHAN_SEL}, 8'h00);
      GROUP_SELECT_LOW_SWITCH = 1'b1;
      HALF_SWITCH = 1'b0;
      PRINTER_USER_SWAP_JUMPER = 1'b0;
      settle();
      $display("t_usel done");
   endtask

   task automatic t_chan();
      logic [7:0] q, oe;
      logic [2:0] jw[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      int w, i, n0;
      bus(1'b1, 8'h17, 8'h05, q, oe, w);
      for (i = 0; i < 4; i++) begin
         WAIT_JUMPER = jw[i];
         settle();
         n0 = rd_pulses;
         bus(1'b0, 8'(8'h10 + i), 8'h00, q, oe, w);
         chk("wait states", 8'(w), 8'(i));
         chk("channel read strobe", 8'(rd_pulses - n0), 8'h01);
         chk("channel read", q, {4'h2, 2'h0, 2'(i)});
         chk("channel drive", oe, 8'h00);
      end
      WAIT_JUMPER = 3'h7;
      settle();
      n0 = wr_pulses;
      bus(1'b1, 8'h10, 8'h96, q, oe, w);
      chk("write wait states", 8'(w), 8'h03);
      chk("channel wdata", CHAN_WDATA, 8'h96);
      chk("channel write strobe", 8'(wr_pulses - n0), 8'h01);
      bus(1'b1, 8'h11, 8'h69, q, oe, w);
      chk("sync char register", {6'h00, CHAN_REG}, 8'h01);
      chk("sync char data", CHAN_WDATA, 8'h69);
      bus(1'b1, 8'h17, 8'h04, q, oe, w);
      bus(1'b0, 8'h10, 8'h00, q, oe, w);
      chk("option switches", q, 8'h3C);
      $display("t_chan done");
   endtask

   // Polled interrupt status, masks and routing
   task automatic t_irq();
      logic [7:0] q, oe;
      int w, n0;
      TX_PEND = 4'hA;
      RX_PEND = 4'h5;
      bus(1'b1, 8'h14, 8'h3F, q, oe, w);
      chk("mask wait states", 8'(w), 8'h00);
      bus(1'b1, 8'h15, 8'h0F, q, oe, w);
      settle();
      chk("irq lines", VI_OE_N, 8'hFD);
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("tx status", {4'h0, q[7:4]}, 8'h0A);
      chk("tx drive", oe, 8'h0F);
      bus(1'b0, 8'h15, 8'h00, q, oe, w);
      chk("rx status", {4'h0, q[7:4]}, 8'h05);
      bus(1'b1, 8'h15, 8'hC0, q, oe, w);
      settle();
      chk("irq lines rx", VI_OE_N, 8'hBD);
      bus(1'b1, 8'h17, 8'h01, q, oe, w);
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("partner half drive", oe, 8'h0F);
      bus(1'b1, 8'h17, 8'h0C, q, oe, w);
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("other group drive", oe, 8'hFF);
      n0 = rd_pulses;
      bus(1'b0, 8'h10, 8'h00, q, oe, w);
      chk("other user drive", oe, 8'hFF);
      chk("other user strobe", 8'(rd_pulses - n0), 8'h00);
      bus(1'b1, 8'h14, 8'h00, q, oe, w);
      settle();
      chk("ignored mask", VI_OE_N, 8'hBD);
      NIBBLE_STEER_SWITCH = 1'b0;
      settle();
      bus(1'b1, 8'h17, 8'h06, q, oe, w);
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("low nibble status", {4'h0, q[3:0]}, 8'h0A);
      chk("low nibble drive", oe, 8'hF0);
      bus(1'b0, 8'h15, 8'h00, q, oe, w);
      chk("low nibble rx status", q, 8'h05);
      $display("t_irq done");
   endtask

   task automatic t_decode();
      logic [7:0] q, oe;
      int w;
      bus(1'b0, 8'h16, 8'h00, q, oe, w);
      chk("unused port drive", oe, 8'hFF);
      bus(1'b0, 8'h17, 8'h00, q, oe, w);
      chk("user select read drive", oe, 8'hFF);
      bus(1'b0, 8'h1C, 8'h00, q, oe, w);
      chk("other block drive", oe, 8'hFF);
      PORT_BLOCK_DISABLE = 1'b1;
      settle();
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("disabled drive", oe, 8'hFF);
      PORT_BLOCK_DISABLE = 1'b0;
      BASE_SW_CLOSED = 5'h00;
      settle();
      bus(1'b0, 8'hFC, 8'h00, q, oe, w);
      chk("new base drive", oe, 8'hF0);
      bus(1'b0, 8'h14, 8'h00, q, oe, w);
      chk("old base drive", oe, 8'hFF);
      $display("t_decode done");
   endtask

   initial begin
      RESETN = 1'b0;
      BASE_SW_CLOSED = 5'h1D;
      PORT_BLOCK_DISABLE = 1'b0;
      GROUP_SELECT_LOW_SWITCH = 1'b1;
      GROUP_SELECT_HIGH_SWITCH = 1'b1;
      HALF_SWITCH = 1'b0;
      NIBBLE_STEER_SWITCH = 1'b1;
      PRINTER_USER_SWAP_JUMPER = 1'b0;
      WAIT_JUMPER = 3'h0;
      OPTION_SW = 8'h3C;
      IRQ_ROUTE = 64'h8040201008040201;
      TX_PEND = 4'h0;
      RX_PEND = 4'h0;
      repeat (20) @(posedge CLOCK);
      #1;
      chk("reset data drive", DATA_IN_OE_N, 8'hFF);
      chk("reset irq lines", VI_OE_N, 8'hFF);
      chk("ready level", {7'h00, RDY_O}, 8'h00);
      chk("irq level", VI_O, 8'h00);
      RESETN = 1'b1;
      settle();
      t_usel();
      t_chan();
      t_irq();
      t_decode();
      end_sim();
   end
endmodule // multi_user_io_port_decoder_bench

`default_nettype wire
